//--- pfl_core.sv
`timescale 1ns/1ps
module pfl_core
  import pfl_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Ramp engine and analog comparators.
  input wire logic ramp_speedup_flag,
  input wire logic pump_below_low_cmp,
  input wire logic pump_above_high_cmp,
  input wire logic lock_detect_in,
  // Analog and divider controls.
  output logic [4:0] pump_gain,
  output logic [2:0] div_shift,
  output logic speedup_active,
  output logic lock_indicator,
  // Interrupt.
  output logic irq
);

  // Register port carrier.
  pfl_bus_req_t bus;

  // Stored register fields.
  logic [7:0] div_speedup;
  logic [7:0] normal_gain;
  logic [7:0] gain_timer_hi;
  logic [5:0] pump_low_threshold;
  logic [5:0] pump_high_threshold;
  logic [7:0] timer_lo;
  logic [PFL_IRQ_W-1:0] irq_status;
  logic [PFL_IRQ_W-1:0] irq_mask;

  // Next values of the stored fields and of the read data.
  logic [7:0] next_div_speedup;
  logic [7:0] next_normal_gain;
  logic [7:0] next_gain_timer_hi;
  logic [5:0] next_low_thr;
  logic [5:0] next_high_thr;
  logic [7:0] next_timer_lo;
  logic [PFL_IRQ_W-1:0] next_irq_status;
  logic [PFL_IRQ_W-1:0] next_irq_mask;
  logic [7:0] next_rdata;

  // Synchronised pin levels and their history.
  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic ramp_meta;
  logic ramp_fl;
  logic pump_above_low_bit;
  logic pump_above_high_bit;
  logic lock_sync;
  logic prev_above_low;
  logic prev_above_high;

  // Speed-up timer and the controls that it selects.
  logic timer_start;
  logic timer_running;
  logic timer_done;
  logic [10:0] speedup_timer_count;
  logic [1:0] speedup_rate_factor;
  logic [2:0] next_div_shift;
  logic [4:0] next_pump_gain;
  logic next_lock;

  // Events that set interrupt status bits.
  logic [PFL_IRQ_W-1:0] events;

  // Decode the slip-reduction code into a divider shift.
  // The reserved code falls through to no scaling, like code zero.
  function automatic logic [2:0] pfl_rate_shift(input logic [1:0] code);
    if (code == PFL_RATE_X2) begin
      pfl_rate_shift = 3'h1;
    end else if (code == PFL_RATE_X4) begin
      pfl_rate_shift = 3'h2;
    end else begin
      pfl_rate_shift = 3'h0;
    end
  endfunction

  // Gather the register port into one carrier.
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // External pins cross into the system clock.
  // The comparators are analog and the lock level is untimed, so each passes two flip-flops.
  assign sync_in = {lock_detect_in, pump_above_high_cmp, pump_below_low_cmp};

  pfl_sync u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .din(sync_in),
    .dout(sync_out)
  );

  // The low comparator pin is high below the threshold; its status bit is high above it.
  assign pump_above_low_bit = ~sync_out[0];
  assign pump_above_high_bit = sync_out[1];
  assign lock_sync = sync_out[2];

  // The ramp flag comes from the ramp engine's own timing, so it also passes two flip-flops.
  // Only the second stage is read, so a metastable first stage never reaches the controls.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ramp_meta <= 1'b0;
      ramp_fl <= 1'b0;
    end else begin
      ramp_meta <= ramp_speedup_flag;
      ramp_fl <= ramp_meta;
    end
  end

  // Timer setup: a write to the feedback divider index starts it.
  // The divider value itself lives elsewhere; only the strobe on its index matters here.
  assign timer_start = bus.wr && (bus.addr == PFL_ADDR_FEEDBACK_DIV);
  assign speedup_timer_count = {gain_timer_hi[7:PFL_TIMER_HI_LSB], timer_lo};
  assign speedup_rate_factor = div_speedup[PFL_RATE_LSB+1:PFL_RATE_LSB];

  pfl_timer u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(timer_start),
    .count(speedup_timer_count),
    .running(timer_running),
    .done(timer_done)
  );

  // Speed-up is in force while timing or during a flagged ramp segment.
  // It is a plain OR of two flip-flops, so it settles early in the cycle after the write.
  assign speedup_active = timer_running || ramp_fl;

  // Gain, divider scaling and lock indicator selection.
  // Either comparator tripping forces the lock indicator low, whatever the lock level.
  always_comb begin
    if (speedup_active) begin
      next_pump_gain = gain_timer_hi[PFL_GAIN_LSB+4:PFL_GAIN_LSB];
      next_div_shift = pfl_rate_shift(speedup_rate_factor);
    end else begin
      next_pump_gain = normal_gain[PFL_GAIN_LSB+4:PFL_GAIN_LSB];
      next_div_shift = 3'h0;
    end
    next_lock = lock_sync && pump_above_low_bit && !pump_above_high_bit;
  end

  // Events for the interrupt status register.
  // Edges are taken from synchronised levels, so each crossing is counted once.
  always_comb begin
    events = '0;
    events[PFL_EV_DONE] = timer_done;
    events[PFL_EV_LOW] = prev_above_low && !pump_above_low_bit;
    events[PFL_EV_HIGH] = !prev_above_high && pump_above_high_bit;
    events[PFL_EV_START] = timer_start;
  end

  // Register writes; status bits clear on a written one, a new event wins.
  // The feedback divider index and unmapped indexes store nothing.
  always_comb begin
    next_div_speedup = div_speedup;
    next_normal_gain = normal_gain;
    next_gain_timer_hi = gain_timer_hi;
    next_low_thr = pump_low_threshold;
    next_high_thr = pump_high_threshold;
    next_timer_lo = timer_lo;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (bus.wr) begin
      if (bus.addr == PFL_ADDR_DIV_SPEEDUP) begin
        next_div_speedup = bus.wdata;
      end else if (bus.addr == PFL_ADDR_NORMAL_GAIN) begin
        next_normal_gain = bus.wdata;
      end else if (bus.addr == PFL_ADDR_GAIN_TIMER_HI) begin
        next_gain_timer_hi = bus.wdata;
      end else if (bus.addr == PFL_ADDR_PUMP_LOW) begin
        next_low_thr = bus.wdata[5:0];
      end else if (bus.addr == PFL_ADDR_PUMP_HIGH) begin
        next_high_thr = bus.wdata[5:0];
      end else if (bus.addr == PFL_ADDR_TIMER_LO) begin
        next_timer_lo = bus.wdata;
      end else if (bus.addr == PFL_ADDR_IRQ_STATUS) begin
        next_irq_status = irq_status & ~bus.wdata[PFL_IRQ_W-1:0];
      end else if (bus.addr == PFL_ADDR_IRQ_MASK) begin
        next_irq_mask = bus.wdata[PFL_IRQ_W-1:0];
      end
    end
    next_irq_status = next_irq_status | events;
  end

  // Read data for the cycle after the read strobe; unmapped reads give zero.
  // Reading has no side effect on the status bits.
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      if (bus.addr == PFL_ADDR_DIV_SPEEDUP) begin
        next_rdata = div_speedup;
      end else if (bus.addr == PFL_ADDR_NORMAL_GAIN) begin
        next_rdata = normal_gain;
      end else if (bus.addr == PFL_ADDR_GAIN_TIMER_HI) begin
        next_rdata = gain_timer_hi;
      end else if (bus.addr == PFL_ADDR_PUMP_LOW) begin
        next_rdata = {1'b0, pump_above_low_bit, pump_low_threshold};
      end else if (bus.addr == PFL_ADDR_PUMP_HIGH) begin
        next_rdata = {1'b0, pump_above_high_bit, pump_high_threshold};
      end else if (bus.addr == PFL_ADDR_TIMER_LO) begin
        next_rdata = timer_lo;
      end else if (bus.addr == PFL_ADDR_IRQ_STATUS) begin
        next_rdata = {4'h0, irq_status};
      end else if (bus.addr == PFL_ADDR_IRQ_MASK) begin
        next_rdata = {4'h0, irq_mask};
      end
    end
  end

  // Configuration registers written over the register port.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_speedup <= PFL_DIV_SPEEDUP_RST;
      normal_gain <= 8'h00;
      gain_timer_hi <= 8'h00;
      pump_low_threshold <= PFL_LOW_THR_RST;
      pump_high_threshold <= PFL_HIGH_THR_RST;
      timer_lo <= 8'h00;
    end else begin
      div_speedup <= next_div_speedup;
      normal_gain <= next_normal_gain;
      gain_timer_hi <= next_gain_timer_hi;
      pump_low_threshold <= next_low_thr;
      pump_high_threshold <= next_high_thr;
      timer_lo <= next_timer_lo;
    end
  end

  // Interrupt status and mask; status bits stay set until software writes a one to them.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // Read data stands for one cycle after the read strobe and is zero otherwise.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Pump gain and divider scaling are registered so that the analog side never sees a glitch.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pump_gain <= 5'h00;
      div_shift <= 3'h0;
    end else begin
      pump_gain <= next_pump_gain;
      div_shift <= next_div_shift;
    end
  end

  // Lock indicator, registered after the comparator and lock levels are combined.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lock_indicator <= 1'b0;
    end else begin
      lock_indicator <= next_lock;
    end
  end

  // Comparator history for edge events; the low history resets to the idle level of its bit,
  // so the release of reset cannot look like a falling crossing.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_above_low <= 1'b1;
      prev_above_high <= 1'b0;
    end else begin
      prev_above_low <= pump_above_low_bit;
      prev_above_high <= pump_above_high_bit;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  // It follows the status and mask registers with no extra delay.
  assign irq = |(irq_status & irq_mask);

endmodule // pfl_core

//--- pfl_pkg.sv
package pfl_pkg;

  // Register indexes on the plain register port.
  localparam logic [7:0] PFL_ADDR_FEEDBACK_DIV = 8'h10;
  localparam logic [7:0] PFL_ADDR_DIV_SPEEDUP = 8'h1b;
  localparam logic [7:0] PFL_ADDR_NORMAL_GAIN = 8'h1c;
  localparam logic [7:0] PFL_ADDR_GAIN_TIMER_HI = 8'h1d;
  localparam logic [7:0] PFL_ADDR_PUMP_LOW = 8'h1e;
  localparam logic [7:0] PFL_ADDR_PUMP_HIGH = 8'h1f;
  localparam logic [7:0] PFL_ADDR_TIMER_LO = 8'h20;
  localparam logic [7:0] PFL_ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] PFL_ADDR_IRQ_MASK = 8'h41;

  // Field positions.
  localparam int PFL_RATE_LSB = 5;
  localparam int PFL_GAIN_LSB = 0;
  localparam int PFL_TIMER_HI_LSB = 5;
  localparam int PFL_FLAG_BIT = 6;
  localparam int PFL_TIMER_SCALE_SHIFT = 5;

  // Reset values.
  localparam logic [5:0] PFL_LOW_THR_RST = 6'h0a;
  localparam logic [5:0] PFL_HIGH_THR_RST = 6'h32;
  localparam logic [7:0] PFL_DIV_SPEEDUP_RST = 8'h08;

  // Slip-reduction codes.
  localparam logic [1:0] PFL_RATE_OFF = 2'h0;
  localparam logic [1:0] PFL_RATE_X2 = 2'h1;
  localparam logic [1:0] PFL_RATE_X4 = 2'h2;

  // Interrupt event bits.
  localparam int PFL_IRQ_W = 4;
  localparam int PFL_EV_DONE = 0;
  localparam int PFL_EV_LOW = 1;
  localparam int PFL_EV_HIGH = 2;
  localparam int PFL_EV_START = 3;

  // Register port signals that travel together.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfl_bus_req_t;

  // Timer states.
  typedef enum logic [0:0] {
    PFL_IDLE = 1'b0,
    PFL_RUN = 1'b1
  } pfl_state_t;

endpackage

//--- pfl_timer.sv
`timescale 1ns/1ps
module pfl_timer
  import pfl_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Control.
  input wire logic start,
  input wire logic [10:0] count,
  // Status.
  output logic running,
  output logic done
);

  pfl_state_t state;
  pfl_state_t next_state;
  logic [15:0] remain;
  logic [15:0] next_remain;
  logic next_done;

  // Load on start from the scaled count, count down, and pulse done at the end.
  always_comb begin
    next_state = state;
    next_remain = remain;
    next_done = 1'b0;
    case (state)
      PFL_IDLE: begin
        if (start && count != 11'h000) begin
          next_state = PFL_RUN;
          next_remain = {count, 5'h00};
        end
      end
      PFL_RUN: begin
        if (start && count != 11'h000) begin
          next_remain = {count, 5'h00};
        end else if (start) begin
          next_state = PFL_IDLE;
          next_remain = 16'h0000;
        end else if (remain == 16'h0001) begin
          next_state = PFL_IDLE;
          next_remain = 16'h0000;
          next_done = 1'b1;
        end else begin
          next_remain = remain - 16'h0001;
        end
      end
      default: next_state = PFL_IDLE;
    endcase
  end

  // Timer registers.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= PFL_IDLE;
      remain <= 16'h0000;
      done <= 1'b0;
    end else begin
      state <= next_state;
      remain <= next_remain;
      done <= next_done;
    end
  end

  assign running = (state == PFL_RUN);

endmodule // pfl_timer

//--- pfl_sync.sv
`timescale 1ns/1ps
module pfl_sync
  import pfl_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [2:0] din,
  output logic [2:0] dout
);

  logic [2:0] meta;

  // Two flip-flops; only the second stage is read outside.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta <= 3'h0;
      dout <= 3'h0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // pfl_sync

//--- pfl_core_properties.sv
`timescale 1ns/1ps
module pfl_core_properties
  import pfl_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Levels in.
  input wire logic ramp_speedup_flag,
  input wire logic pump_below_low_cmp,
  input wire logic pump_above_high_cmp,
  input wire logic lock_detect_in,
  // Controls out.
  input wire logic [4:0] pump_gain,
  input wire logic [2:0] div_shift,
  input wire logic speedup_active,
  input wire logic lock_indicator,
  input wire logic irq
);
  logic [1:0] slip_code;
  logic [4:0] fgain;
  logic [10:0] tcnt;
  logic [15:0] elapsed;
  logic wr_fb;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // A write to the divider index restarts the speed-up period.
  assign wr_fb = reg_wr && reg_addr == PFL_ADDR_FEEDBACK_DIV;
  // Shadows of the speed-up fields and cycles since the last start.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slip_code <= 2'h0;
      fgain <= 5'h00;
      tcnt <= 11'h000;
      elapsed <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == PFL_ADDR_DIV_SPEEDUP) slip_code <= reg_wdata[6:5];
      if (reg_wr && reg_addr == PFL_ADDR_GAIN_TIMER_HI) fgain <= reg_wdata[4:0];
      if (reg_wr && reg_addr == PFL_ADDR_GAIN_TIMER_HI) tcnt[10:8] <= reg_wdata[7:5];
      if (reg_wr && reg_addr == PFL_ADDR_TIMER_LO) tcnt[7:0] <= reg_wdata;
      elapsed <= wr_fb ? 16'h0000 : elapsed + 16'h0001;
    end
  end
  sequence start_s;
    wr_fb && tcnt != 11'h000;
  endsequence
  sequence low_rd_s;
    $stable(pump_below_low_cmp) [*4] ##0 (reg_rd && reg_addr == PFL_ADDR_PUMP_LOW);
  endsequence
  sequence high_rd_s;
    $stable(pump_above_high_cmp) [*4] ##0 (reg_rd && reg_addr == PFL_ADDR_PUMP_HIGH);
  endsequence
  start_timer_a: assert property (start_s |=> speedup_active)
    else $error("speed-up did not start");
  timer_len_a: assert property ($fell(speedup_active) && !ramp_speedup_flag
    && !$past(ramp_speedup_flag, 4) |-> elapsed == {tcnt, 5'h00})
    else $error("speed-up period has wrong length");
  shift_idle_a: assert property (!$past(speedup_active) |-> div_shift == 3'h0)
    else $error("divider scaled outside speed-up");
  shift_code_a: assert property ($past(speedup_active) |-> div_shift ==
    ($past(slip_code) == PFL_RATE_X2 ? 3'h1 : $past(slip_code) == PFL_RATE_X4 ? 3'h2 : 3'h0))
    else $error("divider scale wrong for slip code");
  fast_gain_a: assert property ($past(speedup_active) |-> pump_gain == $past(fgain))
    else $error("speed-up gain not applied");
  low_flag_a: assert property (low_rd_s |=> reg_rdata[6] == !$past(pump_below_low_cmp))
    else $error("low comparator bit wrong");
  high_flag_a: assert property (high_rd_s |=> reg_rdata[6] == $past(pump_above_high_cmp))
    else $error("high comparator bit wrong");
  lock_low_a: assert property ($stable({lock_detect_in, pump_below_low_cmp,
    pump_above_high_cmp}) [*4] |-> lock_indicator ==
    (lock_detect_in && !pump_below_low_cmp && !pump_above_high_cmp))
    else $error("lock indicator not forced low");
endmodule // pfl_core_properties

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top
  import pfl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ramp_speedup_flag = 1'b0;
  logic pump_below_low_cmp = 1'b0;
  logic pump_above_high_cmp = 1'b0;
  logic lock_detect_in = 1'b0;
  logic [7:0] reg_rdata;
  logic [4:0] pump_gain;
  logic [2:0] div_shift;
  logic speedup_active;
  logic lock_indicator;
  logic irq;
  int errors = 0;
  int cmp_count = 0;
  pfl_core pfl_core_inst (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ramp_speedup_flag(ramp_speedup_flag), .pump_below_low_cmp(pump_below_low_cmp),
    .pump_above_high_cmp(pump_above_high_cmp), .lock_detect_in(lock_detect_in),
    .pump_gain(pump_gain), .div_shift(div_shift), .speedup_active(speedup_active),
    .lock_indicator(lock_indicator), .irq(irq));
  // Free-running system clock.
  always #5 clk_sys = ~clk_sys;
  // Compares and counts.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read, data checked in the following cycle.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // Waits whole cycles.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Reset values, including an unmapped index.
  task automatic t_reset;
    rchk(PFL_ADDR_DIV_SPEEDUP, 8'h08);
    rchk(PFL_ADDR_PUMP_LOW, 8'h4a);
    rchk(PFL_ADDR_PUMP_HIGH, 8'h32);
    rchk(PFL_ADDR_GAIN_TIMER_HI, 8'h00);
    rchk(8'h55, 8'h00);
  endtask
  // Every slip code through a 64-cycle speed-up period.
  task automatic t_fast;
    logic [2:0] sh[4] = '{3'h0, 3'h1, 3'h2, 3'h0};
    wr(PFL_ADDR_NORMAL_GAIN, 8'h03);
    wr(PFL_ADDR_GAIN_TIMER_HI, 8'h1f);
    wr(PFL_ADDR_TIMER_LO, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(PFL_ADDR_DIV_SPEEDUP, 8'h08 | 8'(c << 5));
      wr(PFL_ADDR_FEEDBACK_DIV, 8'h00);
      #1 chk({7'h00, speedup_active}, 8'h01);
      cyc(2);
      #1 chk({3'h0, pump_gain}, 8'h1f);
      chk({5'h00, div_shift}, {5'h00, sh[c]});
      cyc(64);
      #1 chk({3'h0, pump_gain}, 8'h03);
      chk({5'h00, div_shift}, 8'h00);
    end
  endtask
  // Restart mid-period, then a zero count.
  task automatic t_reload;
    wr(PFL_ADDR_FEEDBACK_DIV, 8'h00);
    cyc(40);
    wr(PFL_ADDR_FEEDBACK_DIV, 8'h00);
    cyc(40);
    #1 chk({7'h00, speedup_active}, 8'h01);
    cyc(30);
    #1 chk({7'h00, speedup_active}, 8'h00);
    wr(PFL_ADDR_TIMER_LO, 8'h00);
    wr(PFL_ADDR_FEEDBACK_DIV, 8'h00);
    cyc(2);
    #1 chk({7'h00, speedup_active}, 8'h00);
  endtask
  // Flagged ramp segment holds the speed-up state, slip reduction off.
  task automatic t_ramp;
    wr(PFL_ADDR_DIV_SPEEDUP, 8'h08);
    ramp_speedup_flag <= 1'b1;
    cyc(4);
    #1 chk({3'h0, pump_gain}, 8'h1f);
    @(posedge clk_sys);
    ramp_speedup_flag <= 1'b0;
    cyc(5);
    #1 chk({3'h0, pump_gain}, 8'h03);
  endtask
  // Thresholds, read-only flags and the forced-low lock indicator.
  task automatic t_mon;
    wr(PFL_ADDR_PUMP_LOW, 8'hff);
    wr(PFL_ADDR_PUMP_HIGH, 8'hc5);
    lock_detect_in <= 1'b1;
    cyc(4);
    #1 chk({7'h00, lock_indicator}, 8'h01);
    rchk(PFL_ADDR_PUMP_LOW, 8'h7f);
    pump_below_low_cmp <= 1'b1;
    cyc(4);
    #1 chk({7'h00, lock_indicator}, 8'h00);
    rchk(PFL_ADDR_PUMP_LOW, 8'h3f);
    pump_below_low_cmp <= 1'b0;
    pump_above_high_cmp <= 1'b1;
    cyc(4);
    #1 chk({7'h00, lock_indicator}, 8'h00);
    rchk(PFL_ADDR_PUMP_HIGH, 8'h45);
    pump_above_high_cmp <= 1'b0;
  endtask
  // Interrupt raised by a start, masked, then by expiry, then cleared.
  task automatic t_irq;
    wr(PFL_ADDR_IRQ_STATUS, 8'h0f);
    rchk(PFL_ADDR_IRQ_STATUS, 8'h00);
    wr(PFL_ADDR_IRQ_MASK, 8'h08);
    wr(PFL_ADDR_TIMER_LO, 8'h01);
    wr(PFL_ADDR_FEEDBACK_DIV, 8'h00);
    cyc(2);
    #1 chk({7'h00, irq}, 8'h01);
    wr(PFL_ADDR_IRQ_MASK, 8'h00);
    #1 chk({7'h00, irq}, 8'h00);
    cyc(40);
    rchk(PFL_ADDR_IRQ_STATUS, 8'h09);
    wr(PFL_ADDR_IRQ_MASK, 8'h01);
    #1 chk({7'h00, irq}, 8'h01);
    wr(PFL_ADDR_IRQ_STATUS, 8'h01);
    #1 chk({7'h00, irq}, 8'h00);
  endtask
  // Prints the verdict and ends the run.
  task automatic end_sim;
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence after an eight-cycle reset.
  initial begin
    cyc(8);
    rstn <= 1'b1;
    t_reset;
    t_fast;
    t_reload;
    t_ramp;
    t_mon;
    t_irq;
    end_sim;
  end
  // Cuts a hang short.
  initial begin
    #200000;
    errors++;
    end_sim;
  end
endmodule // tb_top
bind pfl_core pfl_core_properties pfl_core_properties_inst (.clk_sys(clk_sys), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ramp_speedup_flag(ramp_speedup_flag),
  .pump_below_low_cmp(pump_below_low_cmp), .pump_above_high_cmp(pump_above_high_cmp),
  .lock_detect_in(lock_detect_in), .pump_gain(pump_gain), .div_shift(div_shift),
  .speedup_active(speedup_active), .lock_indicator(lock_indicator), .irq(irq));
